// [hw/vbis_regs.sv]
// vbis_regs.sv: serial-bus register bank of the vbi slicer and decoder status byte
`timescale 1ns/10ps
`include "vbis_cfg.svh"

// What this block does
// - status bit 0: capture ready when format 0, colour detected when format 1
// - status bit 1: copy protection when format 0, slow time constant when format 1
// - status bit 2 shows the white peak loop active
// - status bits 3 and 4 show gain held at bottom and top limit
// - status bit 5 shows detected field rate, high for 60 hz
// - status bit 6 high when unlocked: hv loop (format 0), horizontal (format 1)
// - status bit 7 high for interlaced input
// - slicer clock select in set-up bits 2..1 resets to 01; others reserved
// - set-up bit 4 stops amplitude searching, default searching
// - set-up bit 5 set allows only error-free framing codes
// - set-up bit 6 clear enables parity check of two bytes after framing code
// - set-up bit 7 selects 50 hz or 60 hz slicer field rate
// - twenty-three line registers for lines 2 to 24 hold two type codes
// - four-bit data type codes decode per table, active video default
// - fixed framing codes per data type; some types use none
// - field-offset bit swaps which nibble applies to which field
// - programmable framing code register resets to 40h
// - horizontal offset is 11 bits: three upper bits plus low byte
// - vertical offset is 9 bits: upper bit plus low byte
// - field-offset bit 7 inverts the field indicator, default inverted
// - six-bit data identifier resets to zero
// - output control bit 4 selects the status byte format
module vbis_regs #(
  parameter logic [6:0] DEV_ADDR = `VBIS_I2C_ADDR
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_rstn,
  input  wire logic                 i_scl,
  input  wire logic                 i_sda,
  output logic                      o_sda,
  output logic                      o_sda_oe,
  input  wire vbis_pkg::vbis_status_t i_status,
  input  wire logic [4:0]           i_line_number,
  input  wire logic                 i_field_two,
  output vbis_pkg::vbis_cfg_t       o_cfg,
  output vbis_pkg::vbis_line_t      o_line,
  output logic                      o_field_id
);

  typedef enum logic [7:0] {
    VBIS_ST_IDLE = 8'h01,
    VBIS_ST_ADDR = 8'h02,
    VBIS_ST_AACK = 8'h04,
    VBIS_ST_SUB  = 8'h08,
    VBIS_ST_WACK = 8'h10,
    VBIS_ST_WRB  = 8'h20,
    VBIS_ST_RDB  = 8'h40,
    VBIS_ST_MACK = 8'h80
  } vbis_state_t;

  // pin synchronisers and edge history
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_prev_q;
  logic       sda_prev_q;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;

  // serial engine
  vbis_state_t st_q,   st_d;
  logic [2:0]  bit_q,  bit_d;
  logic        got8_q, got8_d;
  logic [7:0]  sh_q,   sh_d;
  logic [7:0]  ptr_q,  ptr_d;
  logic        rd_q,   rd_d;
  logic        nack_q, nack_d;
  logic        oe_q,   oe_d;
  logic        wr_en;
  logic [7:0]  rdata;

  // register storage
  logic [7:0] outctl3_q,  outctl3_d;
  logic [7:0] gate_q,     gate_d;
  logic [7:0] setup_q,    setup_d;
  logic [7:0] line_q      [`VBIS_LINE_COUNT];
  logic [7:0] line_d      [`VBIS_LINE_COUNT];
  logic [7:0] sync_q,     sync_d;
  logic [7:0] hoff_q,     hoff_d;
  logic [7:0] voff_q,     voff_d;
  logic [7:0] fofs_q,     fofs_d;
  logic [7:0] sdid_q,     sdid_d;

  // slicer outputs
  vbis_pkg::vbis_line_t line_cfg_q, line_cfg_d;
  logic                 fid_q,      fid_d;

  assign scl_s     = scl_sync_q[1];
  assign sda_s     = sda_sync_q[1];
  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // live status byte, multiplexed by the format select
  function automatic logic [7:0] status_byte(input vbis_pkg::vbis_status_t s,
                                             input logic fmt);
    logic [7:0] b;
    b    = 8'h00;
    b[0] = fmt ? s.colour_detected : s.capture_ready_flag;
    b[1] = fmt ? s.slow_time_constant_flag : s.copy_protect_flag;
    b[2] = s.white_peak_active;
    b[3] = s.gain_at_bottom_limit;
    b[4] = s.gain_at_top_limit;
    b[5] = s.field_rate_detected;
    b[6] = fmt ? s.horizontal_unlocked : s.hv_loop_unlocked;
    b[7] = s.interlace_detected;
    return b;
  endfunction

  function automatic logic in_line_range(input logic [7:0] a);
    return (a >= `VBIS_OFS_LINE_FIRST) && (a <= `VBIS_OFS_LINE_LAST);
  endfunction

  // read multiplexer; unmapped addresses read zero
  always_comb begin
    rdata = 8'h00;
    if (in_line_range(ptr_q)) begin
      rdata = line_q[5'(ptr_q - `VBIS_OFS_LINE_FIRST)];
    end else begin
      case (ptr_q)
        `VBIS_OFS_OUTCTL3:   rdata = outctl3_q;
        `VBIS_OFS_GATE_MSBS: rdata = gate_q;
        `VBIS_OFS_STATUS:    rdata = status_byte(i_status, outctl3_q[`VBIS_BIT_SFS]);
        `VBIS_OFS_SETUP:     rdata = setup_q;
        `VBIS_OFS_SYNC_CODE: rdata = sync_q;
        `VBIS_OFS_HOFF_LO:   rdata = hoff_q;
        `VBIS_OFS_VOFF_LO:   rdata = voff_q;
        `VBIS_OFS_FIELD_OFS: rdata = fofs_q;
        `VBIS_OFS_SDID:      rdata = sdid_q;
        default:             rdata = 8'h00;
      endcase
    end
  end

  // serial engine: sample on scl rise, drive sda after scl fall
  always_comb begin
    st_d   = st_q;
    bit_d  = bit_q;
    got8_d = got8_q;
    sh_d   = sh_q;
    ptr_d  = ptr_q;
    rd_d   = rd_q;
    nack_d = nack_q;
    oe_d   = oe_q;
    wr_en  = 1'b0;
    if (bus_start) begin
      st_d   = VBIS_ST_ADDR;
      bit_d  = 3'h0;
      got8_d = 1'b0;
      oe_d   = 1'b0;
    end else if (bus_stop) begin
      st_d = VBIS_ST_IDLE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      case (st_q)
        VBIS_ST_ADDR, VBIS_ST_SUB, VBIS_ST_WRB: begin
          sh_d   = {sh_q[6:0], sda_s};
          bit_d  = 3'(bit_q + 3'h1);
          got8_d = (bit_q == 3'h7);
        end
        VBIS_ST_RDB: begin
          bit_d  = 3'(bit_q + 3'h1);
          got8_d = (bit_q == 3'h7);
        end
        VBIS_ST_MACK: nack_d = sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_q)
        VBIS_ST_ADDR: begin
          if (got8_q) begin
            got8_d = 1'b0;
            if (sh_q[7:1] == DEV_ADDR) begin
              rd_d = sh_q[0];
              oe_d = 1'b1;
              st_d = VBIS_ST_AACK;
            end else begin
              st_d = VBIS_ST_IDLE;
            end
          end
        end
        VBIS_ST_AACK: begin
          bit_d = 3'h0;
          if (rd_q) begin
            sh_d = rdata;
            oe_d = ~rdata[7];
            st_d = VBIS_ST_RDB;
          end else begin
            oe_d = 1'b0;
            st_d = VBIS_ST_SUB;
          end
        end
        VBIS_ST_SUB: begin
          if (got8_q) begin
            got8_d = 1'b0;
            ptr_d  = sh_q;
            oe_d   = 1'b1;
            st_d   = VBIS_ST_WACK;
          end
        end
        VBIS_ST_WRB: begin
          if (got8_q) begin
            got8_d = 1'b0;
            wr_en  = 1'b1;
            ptr_d  = 8'(ptr_q + 8'h01);
            oe_d   = 1'b1;
            st_d   = VBIS_ST_WACK;
          end
        end
        VBIS_ST_WACK: begin
          bit_d = 3'h0;
          oe_d  = 1'b0;
          st_d  = VBIS_ST_WRB;
        end
        VBIS_ST_RDB: begin
          if (got8_q) begin
            got8_d = 1'b0;
            oe_d   = 1'b0;
            ptr_d  = 8'(ptr_q + 8'h01);
            st_d   = VBIS_ST_MACK;
          end else begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_d = ~sh_q[6];
          end
        end
        VBIS_ST_MACK: begin
          bit_d = 3'h0;
          if (nack_q) begin
            st_d = VBIS_ST_IDLE;
          end else begin
            sh_d = rdata;
            oe_d = ~rdata[7];
            st_d = VBIS_ST_RDB;
          end
        end
        default: ;
      endcase
    end
  end

  // register writes; the status address has no storage
  always_comb begin
    outctl3_d = outctl3_q;
    gate_d    = gate_q;
    setup_d   = setup_q;
    sync_d    = sync_q;
    hoff_d    = hoff_q;
    voff_d    = voff_q;
    fofs_d    = fofs_q;
    sdid_d    = sdid_q;
    for (int i = 0; i < `VBIS_LINE_COUNT; i++) begin
      line_d[i] = line_q[i];
    end
    if (wr_en) begin
      if (in_line_range(ptr_q)) begin
        line_d[5'(ptr_q - `VBIS_OFS_LINE_FIRST)] = sh_q;
      end else begin
        case (ptr_q)
          `VBIS_OFS_OUTCTL3:   outctl3_d = sh_q;
          `VBIS_OFS_GATE_MSBS: gate_d    = sh_q;
          `VBIS_OFS_SETUP:     setup_d   = sh_q;
          `VBIS_OFS_SYNC_CODE: sync_d    = sh_q;
          `VBIS_OFS_HOFF_LO:   hoff_d    = sh_q;
          `VBIS_OFS_VOFF_LO:   voff_d    = sh_q;
          `VBIS_OFS_FIELD_OFS: fofs_d    = sh_q;
          `VBIS_OFS_SDID:      sdid_d    = sh_q & `VBIS_SDID_MASK;
          default: ;
        endcase
      end
    end
  end

  // per-line slicer set-up for the line being decoded
  always_comb begin
    logic [7:0]            lreg;
    logic                  upper;
    vbis_pkg::vbis_dtype_t dt;
    lreg  = `VBIS_RST_LINE;
    dt    = vbis_pkg::VBIS_DT_ACTIVE;
    upper = (i_field_two == fofs_q[`VBIS_BIT_FIELD_INDICATOR_INVERT]);
    if ((i_line_number >= `VBIS_FIRST_LINE) &&
        (i_line_number < 5'(`VBIS_FIRST_LINE + 5'(`VBIS_LINE_COUNT)))) begin
      lreg = line_q[5'(i_line_number - `VBIS_FIRST_LINE)];
    end
    dt = vbis_pkg::vbis_dtype_t'(upper ? lreg[7:4] : lreg[3:0]);
    line_cfg_d.line_data_type_code = dt;
    line_cfg_d.parity_check_on     = ~setup_q[`VBIS_BIT_HAM];
    case (dt)
      vbis_pkg::VBIS_DT_EU_TTX, vbis_pkg::VBIS_DT_US_TTX: begin
        line_cfg_d.sync_code = `VBIS_SYNC_TTX;
        line_cfg_d.sync_bits = 5'd8;
      end
      vbis_pkg::VBIS_DT_EU_CAP, vbis_pkg::VBIS_DT_US_CAP: begin
        line_cfg_d.sync_code = `VBIS_SYNC_CAPTION;
        line_cfg_d.sync_bits = 5'd3;
      end
      vbis_pkg::VBIS_DT_PROG_SVC: begin
        line_cfg_d.sync_code = `VBIS_SYNC_VPS;
        line_cfg_d.sync_bits = 5'd16;
      end
      vbis_pkg::VBIS_DT_WIDE: begin
        line_cfg_d.sync_code = `VBIS_SYNC_WSS;
        line_cfg_d.sync_bits = 5'd24;
      end
      vbis_pkg::VBIS_DT_GEN_TEXT, vbis_pkg::VBIS_DT_TC_EU, vbis_pkg::VBIS_DT_TC_US,
      vbis_pkg::VBIS_DT_JP_TEXT, vbis_pkg::VBIS_DT_FMT_SW: begin
        line_cfg_d.sync_code = {16'h0000, sync_q};
        line_cfg_d.sync_bits = 5'd8;
      end
      default: begin
        line_cfg_d.sync_code = 24'h000000;
        line_cfg_d.sync_bits = 5'd0;
      end
    endcase
    fid_d = i_field_two ^ fofs_q[`VBIS_BIT_FIELD_INDICATOR_INVERT];
  end

  always_ff @(posedge i_clock) begin
    scl_sync_q <= {scl_sync_q[0], i_scl};
    sda_sync_q <= {sda_sync_q[0], i_sda};
    if (!i_rstn) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      st_q       <= VBIS_ST_IDLE;
      bit_q      <= 3'h0;
      got8_q     <= 1'b0;
      sh_q       <= 8'h00;
      ptr_q      <= 8'h00;
      rd_q       <= 1'b0;
      nack_q     <= 1'b0;
      oe_q       <= 1'b0;
      outctl3_q  <= `VBIS_RST_OUTCTL3;
      gate_q     <= `VBIS_RST_GATE_MSBS;
      setup_q    <= `VBIS_RST_SETUP;
      sync_q     <= `VBIS_RST_SYNC_CODE;
      hoff_q     <= `VBIS_RST_HOFF_LO;
      voff_q     <= `VBIS_RST_VOFF_LO;
      fofs_q     <= `VBIS_RST_FIELD_OFS;
      sdid_q     <= `VBIS_RST_SDID;
      for (int i = 0; i < `VBIS_LINE_COUNT; i++) begin
        line_q[i] <= `VBIS_RST_LINE;
      end
      line_cfg_q <= '0;
      fid_q      <= 1'b0;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      st_q       <= st_d;
      bit_q      <= bit_d;
      got8_q     <= got8_d;
      sh_q       <= sh_d;
      ptr_q      <= ptr_d;
      rd_q       <= rd_d;
      nack_q     <= nack_d;
      oe_q       <= oe_d;
      outctl3_q  <= outctl3_d;
      gate_q     <= gate_d;
      setup_q    <= setup_d;
      sync_q     <= sync_d;
      hoff_q     <= hoff_d;
      voff_q     <= voff_d;
      fofs_q     <= fofs_d;
      sdid_q     <= sdid_d;
      for (int i = 0; i < `VBIS_LINE_COUNT; i++) begin
        line_q[i] <= line_d[i];
      end
      line_cfg_q <= line_cfg_d;
      fid_q      <= fid_d;
    end
  end

  // configuration fields straight from register flops
  always_comb begin
    o_cfg.slicer_clock_select          = setup_q[2:1];
    o_cfg.amplitude_search_stop        = setup_q[`VBIS_BIT_HUNT];
    o_cfg.strict_framing_tolerance     = setup_q[`VBIS_BIT_FCE];
    o_cfg.parity_check_disable         = setup_q[`VBIS_BIT_HAM];
    o_cfg.slicer_field_rate_select     = setup_q[`VBIS_BIT_SLICER_FIELD_RATE_SELECT];
    o_cfg.programmable_sync_code       = sync_q;
    o_cfg.horiz_offset                 = {fofs_q[2:0], hoff_q};
    o_cfg.vert_offset                  = {fofs_q[`VBIS_BIT_VERT_OFFSET_UPPER], voff_q};
    o_cfg.field_indicator_invert       = fofs_q[`VBIS_BIT_FIELD_INDICATOR_INVERT];
    o_cfg.slicer_data_identifier_field = sdid_q[5:0];
    o_cfg.gate_start_msb               = gate_q[0];
    o_cfg.gate_stop_msb                = gate_q[1];
    o_cfg.status_format_select         = outctl3_q[`VBIS_BIT_SFS];
  end
  assign o_sda      = 1'b0;
  assign o_sda_oe   = oe_q;
  assign o_line     = line_cfg_q;
  assign o_field_id = fid_q;

endmodule

// [hw/vbis_cfg.svh]
// vbis_cfg.svh: offsets, field positions, reset values and codes of the slicer register bank
`ifndef VBIS_CFG_SVH
`define VBIS_CFG_SVH

`define VBIS_I2C_ADDR        7'h24
`define VBIS_OFS_OUTCTL3     8'h13
`define VBIS_OFS_GATE_MSBS   8'h17
`define VBIS_OFS_STATUS      8'h1f
`define VBIS_OFS_SETUP       8'h40
`define VBIS_OFS_LINE_FIRST  8'h41
`define VBIS_OFS_LINE_LAST   8'h57
`define VBIS_OFS_SYNC_CODE   8'h58
`define VBIS_OFS_HOFF_LO     8'h59
`define VBIS_OFS_VOFF_LO     8'h5a
`define VBIS_OFS_FIELD_OFS   8'h5b
`define VBIS_OFS_SDID        8'h5e

`define VBIS_RST_OUTCTL3     8'h00
`define VBIS_RST_GATE_MSBS   8'h00
`define VBIS_RST_SETUP       8'h02
`define VBIS_RST_LINE        8'hff
`define VBIS_RST_SYNC_CODE   8'h40
`define VBIS_RST_HOFF_LO     8'h00
`define VBIS_RST_VOFF_LO     8'h00
`define VBIS_RST_FIELD_OFS   8'h80
`define VBIS_RST_SDID        8'h00

`define VBIS_BIT_SFS         4
`define VBIS_BIT_HUNT        4
`define VBIS_BIT_FCE         5
`define VBIS_BIT_HAM         6
`define VBIS_BIT_SLICER_FIELD_RATE_SELECT       7
`define VBIS_BIT_FIELD_INDICATOR_INVERT        7
`define VBIS_BIT_VERT_OFFSET_UPPER       4
`define VBIS_SDID_MASK       8'h3f

`define VBIS_FIRST_LINE      5'h02
`define VBIS_LINE_COUNT      23

`define VBIS_SYNC_TTX        24'h000027
`define VBIS_SYNC_CAPTION    24'h000001
`define VBIS_SYNC_VPS        24'h009951
`define VBIS_SYNC_WSS        24'h1e3c1f

`endif

// [hw/vbis_pkg.sv]
// vbis_pkg.sv: types of the slicer register bank
package vbis_pkg;

  typedef enum logic [3:0] {
    VBIS_DT_EU_TTX   = 4'h0, VBIS_DT_EU_CAP  = 4'h1, VBIS_DT_PROG_SVC = 4'h2,
    VBIS_DT_WIDE     = 4'h3, VBIS_DT_US_TTX  = 4'h4, VBIS_DT_US_CAP   = 4'h5,
    VBIS_DT_TESTLINE = 4'h6, VBIS_DT_OVERSMP = 4'h7, VBIS_DT_GEN_TEXT = 4'h8,
    VBIS_DT_TC_EU    = 4'h9, VBIS_DT_TC_US   = 4'ha, VBIS_DT_RESERVED = 4'hb,
    VBIS_DT_US_BCAST = 4'hc, VBIS_DT_JP_TEXT = 4'hd, VBIS_DT_FMT_SW   = 4'he,
    VBIS_DT_ACTIVE   = 4'hf
  } vbis_dtype_t;

  typedef struct packed {
    logic capture_ready_flag;
    logic colour_detected;
    logic copy_protect_flag;
    logic slow_time_constant_flag;
    logic white_peak_active;
    logic gain_at_bottom_limit;
    logic gain_at_top_limit;
    logic field_rate_detected;
    logic hv_loop_unlocked;
    logic horizontal_unlocked;
    logic interlace_detected;
  } vbis_status_t;

  typedef struct packed {
    logic [1:0]  slicer_clock_select;
    logic        amplitude_search_stop;
    logic        strict_framing_tolerance;
    logic        parity_check_disable;
    logic        slicer_field_rate_select;
    logic [7:0]  programmable_sync_code;
    logic [10:0] horiz_offset;
    logic [8:0]  vert_offset;
    logic        field_indicator_invert;
    logic [5:0]  slicer_data_identifier_field;
    logic        gate_start_msb;
    logic        gate_stop_msb;
    logic        status_format_select;
  } vbis_cfg_t;

  typedef struct packed {
    vbis_dtype_t line_data_type_code;
    logic [23:0] sync_code;
    logic [4:0]  sync_bits;
    logic        parity_check_on;
  } vbis_line_t;

endpackage

// [tb/vbis_regs_checker.sv]
// vbis_regs_checker.sv: port assertions on the slicer register bank
`timescale 1ns/10ps
module vbis_regs_checker (
  input wire logic                   i_clock,
  input wire logic                   i_rstn,
  input wire logic                   i_scl,
  input wire logic                   i_sda,
  input wire logic                   o_sda,
  input wire logic                   o_sda_oe,
  input wire vbis_pkg::vbis_status_t i_status,
  input wire logic [4:0]             i_line_number,
  input wire logic                   i_field_two,
  input wire vbis_pkg::vbis_cfg_t    o_cfg,
  input wire vbis_pkg::vbis_line_t   o_line,
  input wire logic                   o_field_id
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  sequence s_run;
    $past(i_rstn);
  endsequence
  sequence s_fresh;
    $rose(i_rstn);
  endsequence
  property p_field_id;
    s_run |-> o_field_id == ($past(i_field_two) ^ $past(o_cfg.field_indicator_invert));
  endproperty
  a_field_id: assert property (p_field_id)
    else $error("field id not inverted as set");
  property p_rst_setup;
    s_fresh |-> o_cfg.slicer_clock_select == 2'h1 && !o_cfg.amplitude_search_stop
      && !o_cfg.parity_check_disable;
  endproperty
  a_rst_setup: assert property (p_rst_setup)
    else $error("set-up reset value wrong");
  property p_rst_sync;
    s_fresh |-> o_cfg.programmable_sync_code == 8'h40;
  endproperty
  a_rst_sync: assert property (p_rst_sync)
    else $error("framing code reset value wrong");
  property p_rst_fofs;
    s_fresh |-> o_cfg.field_indicator_invert && o_cfg.slicer_data_identifier_field == 6'h00;
  endproperty
  a_rst_fofs: assert property (p_rst_fofs)
    else $error("field offset or identifier reset wrong");
  property p_ttx;
    s_run ##0 (o_line.line_data_type_code inside {vbis_pkg::VBIS_DT_EU_TTX,
      vbis_pkg::VBIS_DT_US_TTX}) |-> o_line.sync_code == 24'h000027
      && o_line.sync_bits == 5'h08;
  endproperty
  a_ttx: assert property (p_ttx)
    else $error("teletext framing code wrong");
  property p_vps;
    s_run ##0 o_line.line_data_type_code == vbis_pkg::VBIS_DT_PROG_SVC
      |-> o_line.sync_code == 24'h009951 && o_line.sync_bits == 5'h10;
  endproperty
  a_vps: assert property (p_vps)
    else $error("programme service framing code wrong");
  property p_wss;
    s_run ##0 o_line.line_data_type_code == vbis_pkg::VBIS_DT_WIDE
      |-> o_line.sync_code == 24'h1e3c1f && o_line.sync_bits == 5'h18;
  endproperty
  a_wss: assert property (p_wss)
    else $error("widescreen framing code wrong");
  property p_nosync;
    s_run ##0 (o_line.line_data_type_code inside {vbis_pkg::VBIS_DT_TESTLINE,
      vbis_pkg::VBIS_DT_OVERSMP, vbis_pkg::VBIS_DT_ACTIVE}) |-> o_line.sync_bits == 5'h00;
  endproperty
  a_nosync: assert property (p_nosync)
    else $error("framing code used where none applies");
  property p_prog;
    s_run ##0 o_line.line_data_type_code == vbis_pkg::VBIS_DT_GEN_TEXT
      |-> o_line.sync_code == {16'h0000, $past(o_cfg.programmable_sync_code)}
      && o_line.sync_bits == 5'h08;
  endproperty
  a_prog: assert property (p_prog)
    else $error("programmable framing code not used");
  property p_outside;
    s_run ##0 ($past(i_line_number) < 5'h02 || $past(i_line_number) > 5'h18)
      |-> o_line.line_data_type_code == vbis_pkg::VBIS_DT_ACTIVE;
  endproperty
  a_outside: assert property (p_outside)
    else $error("line outside table not active video");
  property p_parity;
    s_run |-> o_line.parity_check_on == !$past(o_cfg.parity_check_disable);
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity check on while disabled");
endmodule
bind vbis_regs vbis_regs_checker chk (.i_clock(i_clock), .i_rstn(i_rstn), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_status(i_status),
  .i_line_number(i_line_number), .i_field_two(i_field_two), .o_cfg(o_cfg),
  .o_line(o_line), .o_field_id(o_field_id));

// [tb/vbis_host.sv]
// vbis_host.sv: serial bus host model that configures the register bank
`timescale 1ns/10ps
module vbis_host #(
  parameter logic [6:0] DEV = 7'h24
) (
  input  wire logic i_clock,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  int nak;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    nak = 0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // data moves only while the bus clock is low; 400 ns a bit
  task automatic bitx(input logic b, output logic r);
    o_scl <= 1'b0;
    tick(2);
    o_sda <= b;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    r = i_sda;
    tick(2);
  endtask
  // start is edge2(1,0), stop is edge2(0,1); clock stays high after stop
  task automatic edge2(input logic a, input logic b);
    tick(1);
    o_scl <= 1'b0;
    tick(2);
    o_sda <= a;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda <= b;
    tick(4);
  endtask
  task automatic sbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    if (r !== 1'b0) nak++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    edge2(1'b1, 1'b0);
    sbyte({DEV, 1'b0});
    sbyte(a);
    sbyte(d);
    edge2(1'b0, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic r;
    edge2(1'b1, 1'b0);
    sbyte({DEV, 1'b0});
    sbyte(a);
    edge2(1'b1, 1'b0);
    sbyte({DEV, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(1'b1, r);
    edge2(1'b0, 1'b1);
  endtask
  task automatic poke(input logic [6:0] dv);
    edge2(1'b1, 1'b0);
    sbyte({dv, 1'b0});
    edge2(1'b0, 1'b1);
  endtask
endmodule

// [tb/vbis_regs_test.sv]
// vbis_regs_test.sv: self-checking bench of the slicer register bank
`timescale 1ns/10ps
module vbis_regs_test;
  logic                   i_clock;
  logic                   i_rstn;
  logic                   scl;
  logic                   host_sda;
  logic                   o_sda;
  logic                   o_sda_oe;
  logic                   sda_wire;
  vbis_pkg::vbis_status_t i_status;
  logic [4:0]             i_line_number;
  logic                   i_field_two;
  vbis_pkg::vbis_cfg_t    o_cfg;
  vbis_pkg::vbis_line_t   o_line;
  logic                   o_field_id;
  logic [7:0]             rv;
  logic [7:0]             d;
  logic [3:0]             ec;
  int                     miscompares;
  int                     n_checks;
  int                     mdl [256];
  logic [7:0]             ra [11] = '{8'h13, 8'h17, 8'h40, 8'h41, 8'h4c, 8'h57, 8'h58, 8'h59,
                                      8'h5a, 8'h5b, 8'h5e};
  // open-drain data line with pull-up
  assign sda_wire = host_sda & (o_sda | ~o_sda_oe);
  vbis_host host (.i_clock(i_clock), .i_sda(sda_wire), .o_scl(scl), .o_sda(host_sda));
  vbis_regs dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda_wire),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_status(i_status), .i_line_number(i_line_number),
    .i_field_two(i_field_two), .o_cfg(o_cfg), .o_line(o_line), .o_field_id(o_field_id));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_ln(input logic [3:0] gc, input logic gf, input logic [3:0] xc,
                        input logic xf);
    n_checks++;
    if (gc !== xc || gf !== xf) begin
      miscompares++;
      $display("[ERR] %0t line type %h fid %b expected %h %b", $time, gc, gf, xc, xf);
    end
  endtask
  function automatic logic [7:0] st_exp();
    logic f;
    f = mdl[8'h13][4];
    return {i_status.interlace_detected,
            f ? i_status.horizontal_unlocked : i_status.hv_loop_unlocked,
            i_status.field_rate_detected, i_status.gain_at_top_limit,
            i_status.gain_at_bottom_limit, i_status.white_peak_active,
            f ? i_status.slow_time_constant_flag : i_status.copy_protect_flag,
            f ? i_status.colour_detected : i_status.capture_ready_flag};
  endfunction
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h13: return 8'h10;
      8'h40: return 8'hf0;
      8'h5b: return 8'h97;
      default: return 8'hff;
    endcase
  endfunction
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    host.wr(a, v);
    if (a == 8'h5e) mdl[a] = v & 8'h3f;
    else if (a != 8'h1f && a != 8'h5c) mdl[a] = v;
  endtask
  task automatic rchk(input logic [7:0] a);
    host.rd(a, rv);
    cmp8(rv, (a == 8'h1f) ? st_exp() : 8'(mdl[a]));
  endtask
  task automatic cfg_chk();
    logic [7:0] s;
    s = {o_cfg.slicer_field_rate_select, o_cfg.parity_check_disable,
         o_cfg.strict_framing_tolerance, o_cfg.amplitude_search_stop, 4'h0};
    cmp8(s, 8'(mdl[8'h40]) & 8'hf0);
    cmp8({6'h00, o_cfg.slicer_clock_select}, 8'(mdl[8'h40] >> 1) & 8'h03);
    cmp8(o_cfg.horiz_offset[7:0], 8'(mdl[8'h59]));
    cmp8({5'h00, o_cfg.horiz_offset[10:8]}, 8'(mdl[8'h5b]) & 8'h07);
    cmp8(o_cfg.vert_offset[7:0], 8'(mdl[8'h5a]));
    cmp8({7'h00, o_cfg.vert_offset[8]}, 8'(mdl[8'h5b] >> 4) & 8'h01);
    cmp8({7'h00, o_cfg.field_indicator_invert}, 8'(mdl[8'h5b] >> 7) & 8'h01);
    cmp8({2'h0, o_cfg.slicer_data_identifier_field}, 8'(mdl[8'h5e]));
    cmp8({6'h00, o_cfg.gate_stop_msb, o_cfg.gate_start_msb}, 8'(mdl[8'h17]) & 8'h03);
    cmp8({7'h00, o_cfg.status_format_select}, 8'(mdl[8'h13] >> 4) & 8'h01);
    cmp8(o_cfg.programmable_sync_code, 8'(mdl[8'h58]));
  endtask
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  initial begin
    repeat (100000) @(posedge i_clock);
    miscompares++;
    report_and_stop();
  end
  initial begin
    i_rstn = 1'b0;
    i_status = '0;
    i_line_number = 5'h00;
    i_field_two = 1'b0;
    miscompares = 0;
    n_checks = 0;
    foreach (mdl[k]) mdl[k] = 0;
    for (int k = 8'h41; k <= 8'h57; k++) mdl[k] = 8'hff;
    mdl[8'h40] = 8'h02;
    mdl[8'h58] = 8'h40;
    mdl[8'h5b] = 8'h80;
    d = 8'($urandom(38831));
    repeat (20) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_clock);
    foreach (ra[k]) rchk(ra[k]);
    cfg_chk();
    rchk(8'h5c);
    for (int p = 0; p < 3; p++) begin
      foreach (ra[k]) begin
        d = 8'($urandom) & msk(ra[k]);
        if (ra[k] == 8'h40) d = d | 8'h02;
        if (ra[k] == 8'h5b && mdl[8'h5a] > 8'h38) d[4] = 1'b0;
        wreg(ra[k], d);
      end
      wreg(8'h5c, 8'($urandom));
      foreach (ra[k]) rchk(ra[k]);
      cfg_chk();
    end
    for (int f = 0; f < 2; f++) begin
      wreg(8'h13, f[0] ? 8'h10 : 8'h00);
      for (int k = 0; k < 3; k++) begin
        i_status <= vbis_pkg::vbis_status_t'(11'($urandom));
        wreg(8'h1f, 8'($urandom));
        rchk(8'h1f);
        rchk(8'h1f);
      end
    end
    wreg(8'h40, 8'h02);
    for (int c = 0; c < 16; c++) wreg(8'(8'h41 + c), {4'(c), ~4'(c)});
    for (int f = 0; f < 2; f++) begin
      wreg(8'h5b, f[0] ? 8'h80 : 8'h00);
      for (int c = 0; c < 17; c++) begin
        for (int fd = 0; fd < 2; fd++) begin
          i_line_number <= (c == 16) ? 5'h19 : 5'(c + 2);
          i_field_two <= fd[0];
          repeat (2) @(posedge i_clock);
          ec = (c == 16) ? 4'hf : (fd == f) ? 4'(c) : ~4'(c);
          cmp_ln(o_line.line_data_type_code, o_field_id, ec, fd[0] ^ f[0]);
        end
      end
    end
    host.poke(7'h25);
    cmp8(8'(host.nak), 8'h01);
    report_and_stop();
  end
endmodule
